// *** hw/dual_port_io.sv ***
// Top of the dual port I/O block: registers, pin drive and pin read
//
// Behaviour
// R1: first port has one output pin (divider) and two bidirectional timer pins
// R2: drive-select bit 0 gives open drain, 1 gives push-pull on bidirectional pins
// R3: reset sets first port latch to ones and clears drive-select
// R4: latch and pin-input registers sit apart; one reads latch, other live pins
// R5: latch read bits 6..5 and 2..0 carry no meaning; 7, 4, 3 do
// R6: software writes ones into latch bits 2..0
// R7: drive-select bit 2 hands the other port's clock pin to serial clock out
// R8: drive-select bit 1 routes serial data out onto the other port's pin
// R9: drive-select read bits 7..5 and 0 carry no meaning
// R10: software writes zero into drive-select bit 0
// R11: pin-input register shows the two bidirectional pins in bits 4 and 3
// R12: second port has eight pins, each with its own direction bit
// R13: reset clears second port latch, direction and segment select
// R14: segment select wins; else direction 1 drives latch, direction 0 is input
// R15: second port read gives pin, zero, or latch by direction and segment select
// R16: bit read-modify-write rewrites input-mode latches with pin levels
// R17: software clears segment select, then direction, then sets serial enable
// R18: writes land at the edge ending the cycle; pins follow one cycle later
// R19: stop mode without output enable releases second port outputs
//
// Local design decision: the plain strobed port.
`include "dual_port_io_defs.svh"
module dual_port_io #(
   parameter int P5_PINS = `P5_PINS
) (
   input  wire logic                ref_clk_i,
   input  wire logic                rst_i,
   // Register port
   input  wire logic [`ADDR_W-1:0]  reg_addr_i,
   input  wire logic [7:0]          reg_wdata_i,
   input  wire logic                reg_wr_i,
   input  wire logic                reg_rd_i,
   output logic      [7:0]          reg_rdata_o,
   // Internal functions sharing the first port
   input  wire logic                divider_output_i,
   input  wire logic [1:0]          timer_out_i,
   output logic      [1:0]          timer_in_o,
   // Serial pin hand-over toward the other port
   output logic                     serial_clock_pin_enable_o,
   output logic                     serial_dout_pin_enable_o,
   // System control
   input  wire logic                stop_mode_i,
   input  wire logic                global_output_enable_i,
   // First port pins
   output logic                     port3_bit7_pin_o,
   input  wire logic                port3_bit4_pin_i,
   output logic                     port3_bit4_pin_o,
   output logic                     port3_bit4_pin_oe_n_o,
   input  wire logic                port3_bit3_pin_i,
   output logic                     port3_bit3_pin_o,
   output logic                     port3_bit3_pin_oe_n_o,
   // Second port pins and segment data
   input  wire logic [P5_PINS-1:0]  port5_pin_i,
   input  wire logic [P5_PINS-1:0]  lcd_segment_i,
   output logic      [P5_PINS-1:0]  port5_pin_o,
   output logic      [P5_PINS-1:0]  port5_pin_oe_n_o
);

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   // Register byte limits the second port width
   if (P5_PINS < 1 || P5_PINS > `DATA_W) begin : g_chk
      $error("P5_PINS must be between 1 and 8");
   end

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic                   p3_latch7_reg;
   logic                   p3_latch4_reg;
   logic                   p3_latch3_reg;
   logic                   p3_drive4_reg;
   logic                   p3_drive3_reg;
   logic                   clk_pin_en_reg;
   logic                   dout_pin_en_reg;
   logic [P5_PINS-1:0]     p5_latch_reg;
   logic [P5_PINS-1:0]     p5_dir_reg;
   logic [P5_PINS-1:0]     p5_seg_reg;
   logic [1:0]             p3_level;
   logic [P5_PINS-1:0]     p5_level;
   dual_port_io_pkg::reg_sel_t sel;
   dual_port_io_pkg::byte_t    rdata_next;
   dual_port_io_pkg::byte_t    p5_read_byte;
   logic                   wr_p3_latch;
   logic                   wr_p3_drive;
   logic                   wr_p5_latch;
   logic                   wr_p5_dir;
   logic                   wr_p5_seg;
   logic                   p3_val4;
   logic                   p3_val3;
   logic                   p3_out4_next;
   logic                   p3_oe4_n_next;
   logic                   p3_out3_next;
   logic                   p3_oe3_n_next;

   port5_ctl_if #(.W(P5_PINS)) p5_bus ();

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // First port bidirectional pins
   pin_sync #(.W(2)) u_p3_sync (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .pin_i     ({port3_bit4_pin_i, port3_bit3_pin_i}),
      .level_o   (p3_level)
   );

   // Second port pins
   pin_sync #(.W(P5_PINS)) u_p5_sync (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .pin_i     (port5_pin_i),
      .level_o   (p5_level)
   );

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   // Map the address onto one register
   always_comb begin
      case (reg_addr_i)
         `OFS_P3_OUTPUT_LATCH:   sel = dual_port_io_pkg::SEL_P3_LATCH;
         `OFS_P3_DRIVE_SELECT:   sel = dual_port_io_pkg::SEL_P3_DRIVE;
         `OFS_P5_OUTPUT_LATCH:   sel = dual_port_io_pkg::SEL_P5_LATCH;
         `OFS_P5_DIRECTION:      sel = dual_port_io_pkg::SEL_P5_DIR;
         `OFS_P3_PIN_INPUT:      sel = dual_port_io_pkg::SEL_P3_PINS;
         `OFS_P5_SEGMENT_SELECT: sel = dual_port_io_pkg::SEL_P5_SEG;
         default:                sel = dual_port_io_pkg::SEL_NONE;
      endcase
   end

   // Write strobes per register; pin-input register ignores writes
   assign wr_p3_latch = reg_wr_i && (sel == dual_port_io_pkg::SEL_P3_LATCH);
   assign wr_p3_drive = reg_wr_i && (sel == dual_port_io_pkg::SEL_P3_DRIVE);
   assign wr_p5_latch = reg_wr_i && (sel == dual_port_io_pkg::SEL_P5_LATCH);
   assign wr_p5_dir   = reg_wr_i && (sel == dual_port_io_pkg::SEL_P5_DIR);
   assign wr_p5_seg   = reg_wr_i && (sel == dual_port_io_pkg::SEL_P5_SEG);

   // ----------------------------------------------------------------
   // First port registers
   // ----------------------------------------------------------------
   // Output latch: only bits 7, 4 and 3 are stored
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         p3_latch7_reg <= `P3_LATCH_RST; // R3
         p3_latch4_reg <= `P3_LATCH_RST; // R3
         p3_latch3_reg <= `P3_LATCH_RST; // R3
      end else if (wr_p3_latch) begin
         p3_latch7_reg <= reg_wdata_i[`P3_BIT7]; // R18
         p3_latch4_reg <= reg_wdata_i[`P3_BIT4]; // R18
         p3_latch3_reg <= reg_wdata_i[`P3_BIT3]; // R18
      end
   end

   // Drive select and serial pin hand-over bits
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         p3_drive4_reg   <= `P3_DRIVE_RST; // R3
         p3_drive3_reg   <= `P3_DRIVE_RST; // R3
         clk_pin_en_reg  <= `P3_DRIVE_RST; // R3
         dout_pin_en_reg <= `P3_DRIVE_RST; // R3
      end else if (wr_p3_drive) begin
         p3_drive4_reg   <= reg_wdata_i[`P3_BIT4];
         p3_drive3_reg   <= reg_wdata_i[`P3_BIT3];
         clk_pin_en_reg  <= reg_wdata_i[`SEL_CLK_PIN_EN_BIT];  // R7
         dout_pin_en_reg <= reg_wdata_i[`SEL_DOUT_PIN_EN_BIT]; // R8
      end
   end

   // ----------------------------------------------------------------
   // Second port registers
   // ----------------------------------------------------------------
   // Output latch
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         p5_latch_reg <= P5_PINS'(`P5_REG_RST); // R13
      end else if (wr_p5_latch) begin
         p5_latch_reg <= reg_wdata_i[P5_PINS-1:0]; // R18
      end
   end

   // Direction, one bit per pin
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         p5_dir_reg <= P5_PINS'(`P5_REG_RST); // R13
      end else if (wr_p5_dir) begin
         p5_dir_reg <= reg_wdata_i[P5_PINS-1:0]; // R12
      end
   end

   // Segment select, one bit per pin
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         p5_seg_reg <= P5_PINS'(`P5_REG_RST); // R13
      end else if (wr_p5_seg) begin
         p5_seg_reg <= reg_wdata_i[P5_PINS-1:0];
      end
   end

   // ----------------------------------------------------------------
   // Second port per-pin logic
   // ----------------------------------------------------------------
   // Feed the per-pin module
   assign p5_bus.latch     = p5_latch_reg;
   assign p5_bus.dir       = p5_dir_reg;
   assign p5_bus.seg_sel   = p5_seg_reg;
   assign p5_bus.pin_level = p5_level;
   assign p5_bus.lcd_seg   = lcd_segment_i;
   assign p5_bus.hold_hiz  = stop_mode_i && !global_output_enable_i; // R19

   // Mode selection per pin
   port5_pin_ctrl #(.W(P5_PINS)) u_p5_ctrl (
      .bus (p5_bus.ctrl) // R14
   );

   // Widen the read value to a byte
   always_comb begin
      p5_read_byte                = '0;
      p5_read_byte[P5_PINS-1:0]   = p5_bus.read_val; // R15
   end

   // ----------------------------------------------------------------
   // First port pin drive
   // ----------------------------------------------------------------
   // Latch gated by the timer output; a latch of one lets the timer through
   assign p3_val4 = p3_latch4_reg & timer_out_i[1];
   assign p3_val3 = p3_latch3_reg & timer_out_i[0];

   // Push-pull drives both levels; open drain only sinks
   always_comb begin
      if (p3_drive4_reg) begin
         p3_out4_next  = p3_val4; // R2
         p3_oe4_n_next = 1'b0;    // R2
      end else begin
         p3_out4_next  = 1'b0;    // R2
         p3_oe4_n_next = p3_val4; // R2
      end
      if (p3_drive3_reg) begin
         p3_out3_next  = p3_val3; // R2
         p3_oe3_n_next = 1'b0;    // R2
      end else begin
         p3_out3_next  = 1'b0;    // R2
         p3_oe3_n_next = p3_val3; // R2
      end
   end

   // ----------------------------------------------------------------
   // Pin output registers
   // ----------------------------------------------------------------
   // First port pins, one cycle after the register update
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         port3_bit7_pin_o      <= 1'b1;
         port3_bit4_pin_o      <= 1'b0;
         port3_bit4_pin_oe_n_o <= 1'b1;
         port3_bit3_pin_o      <= 1'b0;
         port3_bit3_pin_oe_n_o <= 1'b1;
      end else begin
         port3_bit7_pin_o      <= p3_latch7_reg & divider_output_i; // R1
         port3_bit4_pin_o      <= p3_out4_next;  // R18
         port3_bit4_pin_oe_n_o <= p3_oe4_n_next; // R18
         port3_bit3_pin_o      <= p3_out3_next;  // R18
         port3_bit3_pin_oe_n_o <= p3_oe3_n_next; // R18
      end
   end

   // Second port pins, one cycle after the register update
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         port5_pin_o      <= '0;
         port5_pin_oe_n_o <= '1;
      end else begin
         port5_pin_o      <= p5_bus.drive_val;  // R18
         port5_pin_oe_n_o <= p5_bus.drive_oe_n; // R18
      end
   end

   // Timer inputs and serial hand-over, registered
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         timer_in_o                <= 2'h0;
         serial_clock_pin_enable_o <= 1'b0;
         serial_dout_pin_enable_o  <= 1'b0;
      end else begin
         timer_in_o                <= p3_level;        // R1
         serial_clock_pin_enable_o <= clk_pin_en_reg;  // R7
         serial_dout_pin_enable_o  <= dout_pin_en_reg; // R8
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   // Meaningless bits read as zero; unmapped addresses read zero
   always_comb begin
      rdata_next = `RDATA_RST;
      case (sel)
         dual_port_io_pkg::SEL_P3_LATCH: begin
            rdata_next[`P3_BIT7] = p3_latch7_reg; // R5
            rdata_next[`P3_BIT4] = p3_latch4_reg; // R4
            rdata_next[`P3_BIT3] = p3_latch3_reg; // R4
         end
         dual_port_io_pkg::SEL_P3_DRIVE: begin
            rdata_next[`P3_BIT4]             = p3_drive4_reg;
            rdata_next[`P3_BIT3]             = p3_drive3_reg;
            rdata_next[`SEL_CLK_PIN_EN_BIT]  = clk_pin_en_reg;  // R9
            rdata_next[`SEL_DOUT_PIN_EN_BIT] = dout_pin_en_reg; // R9
         end
         dual_port_io_pkg::SEL_P3_PINS: begin
            rdata_next[`P3_BIT4] = p3_level[1]; // R11
            rdata_next[`P3_BIT3] = p3_level[0]; // R11
         end
         dual_port_io_pkg::SEL_P5_LATCH: begin
            rdata_next = p5_read_byte; // R16
         end
         dual_port_io_pkg::SEL_P5_DIR: begin
            rdata_next[P5_PINS-1:0] = p5_dir_reg;
         end
         dual_port_io_pkg::SEL_P5_SEG: begin
            rdata_next[P5_PINS-1:0] = p5_seg_reg;
         end
         default: begin
            rdata_next = `RDATA_RST;
         end
      endcase
   end

   // Read data stand for the single cycle after the strobe
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         reg_rdata_o <= `RDATA_RST;
      end else if (reg_rd_i) begin
         reg_rdata_o <= rdata_next;
      end else begin
         reg_rdata_o <= `RDATA_RST;
      end
   end

endmodule

// *** inc/dual_port_io_defs.svh ***
// Register offsets, field positions, reset values and widths for the dual port I/O block
`ifndef DUAL_PORT_IO_DEFS_SVH
`define DUAL_PORT_IO_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADDR_W                12
`define OFS_P3_OUTPUT_LATCH   12'h003
`define OFS_P3_DRIVE_SELECT   12'h004
`define OFS_P5_OUTPUT_LATCH   12'h005
`define OFS_P5_DIRECTION      12'h00A
`define OFS_P3_PIN_INPUT      12'hF9D
`define OFS_P5_SEGMENT_SELECT 12'hF9F

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define P3_BIT7               7
`define P3_BIT4               4
`define P3_BIT3               3
`define SEL_CLK_PIN_EN_BIT    2
`define SEL_DOUT_PIN_EN_BIT   1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define P3_LATCH_RST          1'h1
`define P3_DRIVE_RST          1'h0
`define P5_REG_RST            8'h00
`define RDATA_RST             8'h00

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define DATA_W                8
`define P5_PINS               8
`define P3_BIDIR_PINS         2

`endif

// *** inc/dual_port_io_pkg.sv ***
// Types shared by the dual port I/O block
package dual_port_io_pkg;

   // Register addressed by the current access
   typedef enum logic [2:0] {
      SEL_NONE,
      SEL_P3_LATCH,
      SEL_P3_DRIVE,
      SEL_P5_LATCH,
      SEL_P5_DIR,
      SEL_P3_PINS,
      SEL_P5_SEG
   } reg_sel_t;

   // One register byte
   typedef logic [7:0] byte_t;

endpackage

// *** inc/port5_ctl_if.sv ***
// Signals between the top and the second port's per-pin logic
interface port5_ctl_if #(parameter int W = 8);
   logic [W-1:0] latch;
   logic [W-1:0] dir;
   logic [W-1:0] seg_sel;
   logic [W-1:0] pin_level;
   logic [W-1:0] lcd_seg;
   logic         hold_hiz;
   logic [W-1:0] drive_val;
   logic [W-1:0] drive_oe_n;
   logic [W-1:0] read_val;

   modport top  (output latch, dir, seg_sel, pin_level, lcd_seg, hold_hiz,
                 input  drive_val, drive_oe_n, read_val);
   modport ctrl (input  latch, dir, seg_sel, pin_level, lcd_seg, hold_hiz,
                 output drive_val, drive_oe_n, read_val);
endinterface

// *** hw/pin_sync.sv ***
// Two flip-flop synchroniser for pin levels
module pin_sync #(
   parameter int W = 2
) (
   input  wire logic         ref_clk_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] pin_i,
   output logic      [W-1:0] level_o
);
   logic [W-1:0] meta_reg;

   if (W < 1) begin : g_chk
      $error("pin_sync needs at least one bit");
   end

   // First stage feeds only the second
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_reg <= '0;
         level_o  <= '0;
      end else begin
         meta_reg <= pin_i;
         level_o  <= meta_reg;
      end
   end
endmodule

// *** hw/port5_pin_ctrl.sv ***
// Per-pin drive and read logic of the second port
module port5_pin_ctrl #(
   parameter int W = 8
) (
   port5_ctl_if.ctrl bus
);
   if (W < 1) begin : g_chk
      $error("port5_pin_ctrl needs at least one pin");
   end

   for (genvar i = 0; i < W; i++) begin : g_pin
      // Segment select overrides direction
      always_comb begin
         if (bus.seg_sel[i]) begin
            bus.drive_val[i]  = bus.lcd_seg[i];
            bus.drive_oe_n[i] = bus.hold_hiz;
         end else if (bus.dir[i]) begin
            bus.drive_val[i]  = bus.latch[i];
            bus.drive_oe_n[i] = bus.hold_hiz;
         end else begin
            bus.drive_val[i]  = 1'b0;
            bus.drive_oe_n[i] = 1'b1;
         end
      end

      // Read value per direction and segment select
      always_comb begin
         if (bus.dir[i]) begin
            bus.read_val[i] = bus.latch[i];
         end else if (bus.seg_sel[i]) begin
            bus.read_val[i] = 1'b0;
         end else begin
            bus.read_val[i] = bus.pin_level[i];
         end
      end
   end
endmodule

// *** verif/board_pins.sv ***
// Board model for the package pins of the dual port I/O block
module board_pins (
   input  wire logic [1:0] p3_out_i,
   input  wire logic [1:0] p3_oe_n_i,
   input  wire logic [7:0] p5_out_i,
   input  wire logic [7:0] p5_oe_n_i,
   input  wire logic [7:0] p5_ext_i,
   output logic      [1:0] p3_level_o,
   output logic      [7:0] p5_level_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------
   // Pin levels
   // ------------
   // Released first-port pins rise to the pull-up
   assign p3_level_o = p3_oe_n_i | p3_out_i;
   // Released second-port pins follow the outside source
   assign p5_level_o = (~p5_oe_n_i & p5_out_i) | (p5_oe_n_i & p5_ext_i);
endmodule

// *** verif/dual_port_io_properties.sv ***
// Port-level checks of the dual port I/O block
`include "dual_port_io_defs.svh"
module dual_port_io_properties #(
   parameter int P5_PINS = 8
) (
   input wire logic               ref_clk_i,
   input wire logic               rst_i,
   input wire logic [`ADDR_W-1:0] reg_addr_i,
   input wire logic [7:0]         reg_wdata_i,
   input wire logic               reg_wr_i,
   input wire logic               reg_rd_i,
   input wire logic [7:0]         reg_rdata_o,
   input wire logic               stop_mode_i,
   input wire logic               global_output_enable_i,
   input wire logic               port3_bit7_pin_o,
   input wire logic               port3_bit4_pin_i,
   input wire logic               port3_bit4_pin_o,
   input wire logic               port3_bit4_pin_oe_n_o,
   input wire logic               port3_bit3_pin_i,
   input wire logic               port3_bit3_pin_o,
   input wire logic               port3_bit3_pin_oe_n_o,
   input wire logic               serial_clock_pin_enable_o,
   input wire logic               serial_dout_pin_enable_o,
   input wire logic [P5_PINS-1:0] lcd_segment_i,
   input wire logic [P5_PINS-1:0] port5_pin_o,
   input wire logic [P5_PINS-1:0] port5_pin_oe_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------
   // Sequences
   // ------------
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);
   // Lone write to an address
   sequence wr_once(a);
      reg_wr_i && reg_addr_i == a ##1 !(reg_wr_i && reg_addr_i == a);
   endsequence
   // Timer pins unchanged for four samples
   sequence pins_steady;
      $stable({port3_bit4_pin_i, port3_bit3_pin_i}) [*4];
   endsequence
   // Direction all out, latch write, latch read back to back
   sequence dir_then_latch;
      reg_wr_i && reg_addr_i == `OFS_P5_DIRECTION && reg_wdata_i == 8'hFF
      ##1 reg_wr_i && reg_addr_i == `OFS_P5_OUTPUT_LATCH
      ##1 reg_rd_i && reg_addr_i == `OFS_P5_OUTPUT_LATCH;
   endsequence
   // ------------
   // Assertions
   // ------------
   chk_rdata_idle: assert property (
      !$past(reg_rd_i) |-> reg_rdata_o == 8'h00) else $error("read data outside read slot");
   chk_pin_read: assert property (
      pins_steady ##0 (reg_rd_i && reg_addr_i == `OFS_P3_PIN_INPUT)
      |=> reg_rdata_o[4:3] == $past({port3_bit4_pin_i, port3_bit3_pin_i}))
      else $error("pin input read wrong");
   chk_stop_release: assert property (
      stop_mode_i && !global_output_enable_i |=> &port5_pin_oe_n_o)
      else $error("outputs not released in stop");
   chk_open_drain: assert property (
      (port3_bit4_pin_o |-> !port3_bit4_pin_oe_n_o)
      and (port3_bit3_pin_o |-> !port3_bit3_pin_oe_n_o)) else $error("high level not driven");
   chk_reset_values: assert property (
      $fell(rst_i) |-> port3_bit7_pin_o && &port5_pin_oe_n_o
      && !serial_clock_pin_enable_o && !serial_dout_pin_enable_o)
      else $error("reset values wrong");
   chk_clk_enable: assert property (
      wr_once(`OFS_P3_DRIVE_SELECT) |=> serial_clock_pin_enable_o == $past(reg_wdata_i[2], 2))
      else $error("clock pin enable wrong");
   chk_dout_enable: assert property (
      wr_once(`OFS_P3_DRIVE_SELECT) |=> serial_dout_pin_enable_o == $past(reg_wdata_i[1], 2))
      else $error("data pin enable wrong");
   chk_latch_read: assert property (
      dir_then_latch |=> reg_rdata_o == $past(reg_wdata_i, 2)) else $error("latch read wrong");
   chk_seg_drive: assert property (
      reg_wr_i && reg_addr_i == `OFS_P5_SEGMENT_SELECT && reg_wdata_i == 8'hFF
      ##1 !(reg_wr_i && reg_addr_i == `OFS_P5_SEGMENT_SELECT)
      |=> port5_pin_o == $past(lcd_segment_i)) else $error("segment data not driven");
endmodule

bind dual_port_io dual_port_io_properties #(.P5_PINS(P5_PINS)) i_props (.*);

// *** verif/test_dual_port_io.sv ***
// Self-checking testbench of the dual port I/O block
`include "dual_port_io_defs.svh"
module test_dual_port_io;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [11:0] reg_addr_i = 12'h000;
   logic [7:0]  reg_wdata_i = 8'h00;
   logic        reg_wr_i = 1'b0;
   logic        reg_rd_i = 1'b0;
   logic [7:0]  reg_rdata_o;
   logic        divider_output_i = 1'b1;
   logic [1:0]  timer_out_i = 2'h1;
   logic [1:0]  timer_in_o;
   logic        serial_clock_pin_enable_o;
   logic        serial_dout_pin_enable_o;
   logic        stop_mode_i = 1'b0;
   logic        global_output_enable_i = 1'b1;
   logic        port3_bit7_pin_o;
   wire         port3_bit4_pin_i;
   logic        port3_bit4_pin_o;
   logic        port3_bit4_pin_oe_n_o;
   wire         port3_bit3_pin_i;
   logic        port3_bit3_pin_o;
   logic        port3_bit3_pin_oe_n_o;
   wire [7:0]   port5_pin_i;
   logic [7:0]  lcd_segment_i = 8'h00;
   logic [7:0]  port5_pin_o;
   logic [7:0]  port5_pin_oe_n_o;
   wire [3:0]   p3_drv = {port3_bit4_pin_o, port3_bit4_pin_oe_n_o,
                          port3_bit3_pin_o, port3_bit3_pin_oe_n_o};
   logic [7:0]  p5_ext = 8'h00;
   logic [7:0]  junk;
   int          bad_count = 0;
   int          num_checks = 0;

   dual_port_io i_dut (.*);
   board_pins i_board (
      .p3_out_i   ({port3_bit4_pin_o, port3_bit3_pin_o}),
      .p3_oe_n_i  ({port3_bit4_pin_oe_n_o, port3_bit3_pin_oe_n_o}),
      .p5_out_i   (port5_pin_o),
      .p5_oe_n_i  (port5_pin_oe_n_o),
      .p5_ext_i   (p5_ext),
      .p3_level_o ({port3_bit4_pin_i, port3_bit3_pin_i}),
      .p5_level_o (port5_pin_i)
   );
   // ------------
   // Clock and common tasks
   // ------------
   initial begin
      forever #2.5 ref_clk_i = ~ref_clk_i;
   end
   // Compare and count
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // One bus cycle; returns read data left by the previous cycle
   task bus(input logic w, input logic r, input logic [11:0] a,
            input logic [7:0] d, output logic [7:0] q);
      reg_wr_i <= w;
      reg_rd_i <= r;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge ref_clk_i);
      q = reg_rdata_o;
   endtask
   task wr(input logic [11:0] a, input logic [7:0] d);
      bus(1'b1, 1'b0, a, d, junk);
   endtask
   task idle(input int n);
      repeat (n) bus(1'b0, 1'b0, 12'h000, 8'h00, junk);
   endtask
   task rdchk(input logic [11:0] a, input logic [7:0] exp);
      logic [7:0] q;
      bus(1'b0, 1'b1, a, 8'h00, junk);
      bus(1'b0, 1'b0, 12'h000, 8'h00, q);
      chk(q, exp);
   endtask
   // ------------
   // Scenarios
   // ------------
   task t_reset;
      rdchk(`OFS_P3_OUTPUT_LATCH, 8'h98);
      rdchk(`OFS_P3_DRIVE_SELECT, 8'h00);
      rdchk(`OFS_P5_OUTPUT_LATCH, 8'h00);
      rdchk(`OFS_P5_DIRECTION, 8'h00);
      rdchk(`OFS_P5_SEGMENT_SELECT, 8'h00);
      rdchk(12'h123, 8'h00);
      chk({7'h00, port3_bit7_pin_o}, 8'h01);
      chk(port5_pin_oe_n_o, 8'hFF);
   endtask
   task t_port3;
      wr(`OFS_P3_OUTPUT_LATCH, 8'h07);
      rdchk(`OFS_P3_OUTPUT_LATCH, 8'h00);
      chk({7'h00, port3_bit7_pin_o}, 8'h00);
      wr(`OFS_P3_OUTPUT_LATCH, 8'hFF);
      wr(`OFS_P3_DRIVE_SELECT, 8'h18);
      divider_output_i <= 1'b0;
      timer_out_i <= 2'h3;
      idle(2);
      chk({7'h00, port3_bit7_pin_o}, 8'h00);
      chk({4'h0, p3_drv}, 8'h0A);
      wr(`OFS_P3_DRIVE_SELECT, 8'h00);
      timer_out_i <= 2'h1;
      wr(`OFS_P3_PIN_INPUT, 8'h00);
      idle(4);
      chk({4'h0, p3_drv}, 8'h01);
      chk({6'h00, timer_in_o}, 8'h01);
      rdchk(`OFS_P3_PIN_INPUT, 8'h08);
      rdchk(`OFS_P3_OUTPUT_LATCH, 8'h98);
   endtask
   task t_serial;
      wr(`OFS_P5_SEGMENT_SELECT, 8'h00);
      wr(`OFS_P5_DIRECTION, 8'h00);
      wr(`OFS_P3_DRIVE_SELECT, 8'h04);
      idle(2);
      chk({6'h00, serial_clock_pin_enable_o, serial_dout_pin_enable_o}, 8'h02);
      wr(`OFS_P3_DRIVE_SELECT, 8'h02);
      idle(2);
      chk({6'h00, serial_clock_pin_enable_o, serial_dout_pin_enable_o}, 8'h01);
      rdchk(`OFS_P3_DRIVE_SELECT, 8'h02);
   endtask
   task t_port5;
      lcd_segment_i <= 8'h5A;
      p5_ext <= 8'h5F;
      wr(`OFS_P5_SEGMENT_SELECT, 8'hFF);
      idle(2);
      chk(port5_pin_o, 8'h5A);
      wr(`OFS_P5_SEGMENT_SELECT, 8'h0C);
      wr(`OFS_P5_DIRECTION, 8'hFF);
      wr(`OFS_P5_OUTPUT_LATCH, 8'hA5);
      rdchk(`OFS_P5_OUTPUT_LATCH, 8'hA5);
      wr(`OFS_P5_DIRECTION, 8'hF0);
      idle(4);
      chk(port5_pin_oe_n_o, 8'h03);
      chk(port5_pin_o, 8'hA8);
      rdchk(`OFS_P5_OUTPUT_LATCH, 8'hA3);
      wr(`OFS_P5_OUTPUT_LATCH, 8'hA3);
      wr(`OFS_P5_DIRECTION, 8'hFF);
      rdchk(`OFS_P5_OUTPUT_LATCH, 8'hA3);
   endtask
   task t_stop;
      wr(`OFS_P5_DIRECTION, 8'hF0);
      stop_mode_i <= 1'b1;
      idle(2);
      chk(port5_pin_oe_n_o, 8'h03);
      global_output_enable_i <= 1'b0;
      idle(2);
      chk(port5_pin_oe_n_o, 8'hFF);
      stop_mode_i <= 1'b0;
      idle(2);
      chk(port5_pin_oe_n_o, 8'h03);
   endtask
   // ------------
   // Run control
   // ------------
   task end_of_test;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Watchdog well beyond the roughly ninety cycles of the run
   initial begin
      #20us;
      bad_count++;
      end_of_test;
   end
   initial begin
      repeat (20) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      @(posedge ref_clk_i);
      t_reset;
      t_port3;
      t_serial;
      t_port5;
      t_stop;
      end_of_test;
   end
endmodule
